// ==== core/fault_resp.sv ====
`timescale 1ns/1ps
module fault_resp import fault_track_pkg::*; (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_tick,
  input  wire logic       i_fault,
  input  wire logic       i_clear_ok,
  input  wire logic       i_restart,
  input  wire fault_cfg_t i_cfg,
  output logic            o_shutdown,
  output logic            o_latched
);
  typedef enum logic [2:0] {st_run, st_grace, st_wait, st_hold, st_latched} fstate_t;
  fstate_t    state;
  logic [7:0] cnt;
  logic [2:0] tries;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= st_run;
      cnt   <= 8'h0;
    end else begin
      unique case (state)
        st_run: begin
          if (i_fault) begin
            cnt <= i_cfg.delay_ms;
            case (i_cfg.mode)
              FR_RETRY_INF: state <= st_wait;
              FR_RETRY_CNT: state <= (tries >= i_cfg.retries) ? st_latched : st_wait;
              FR_DELAYED:   state <= st_grace;
              FR_CONTINUE:  state <= st_run;
              default:      state <= st_hold;
            endcase
          end
        end
        st_grace: begin
          if (!i_fault) begin
            state <= st_run;
          end else if (i_tick) begin
            if (cnt == 8'h0) begin
              state <= st_latched;
            end else begin
              cnt <= cnt - 8'h1;
            end
          end
        end
        st_wait: begin
          if (cnt == 8'h0) begin
            if (i_clear_ok) begin
              state <= st_run;
            end else if (i_tick) begin
              cnt <= i_cfg.delay_ms;
            end
          end else if (i_tick) begin
            cnt <= cnt - 8'h1;
          end
        end
        st_hold: begin
          if (i_clear_ok) state <= st_run;
        end
        st_latched: begin
          if (i_restart) state <= st_run;
        end
      endcase
    end
  end

  // attempts count up on every counted shutdown that retries, not the one that latches; only a reset or a restart clears them
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tries <= 3'h0;
    end else if (i_restart) begin
      tries <= 3'h0;
    end else if (state == st_run && i_fault && i_cfg.mode == FR_RETRY_CNT && tries < i_cfg.retries) begin
      tries <= tries + 3'h1;
    end
  end

  assign o_shutdown = (state != st_run) && (state != st_grace);
  assign o_latched  = (state == st_latched);

  a_hold_release: assert property (@(posedge i_clk) disable iff (i_reset)
    state == st_hold && i_clear_ok |=> !o_shutdown)
    else $error("hold state did not release after fault cleared");
  a_immediate_off: assert property (@(posedge i_clk) disable iff (i_reset)
    state == st_run && i_fault && i_cfg.mode == FR_IMMEDIATE |=> o_shutdown)
    else $error("immediate response did not shut down");
  a_continue_runs: assert property (@(posedge i_clk) disable iff (i_reset)
    state == st_run && i_fault && i_cfg.mode == FR_CONTINUE |=> !o_shutdown)
    else $error("continue response shut down");
  a_latch_stays: assert property (@(posedge i_clk) disable iff (i_reset)
    o_latched && !i_restart |=> o_latched)
    else $error("latched shutdown released without restart");
  a_wait_no_early: assert property (@(posedge i_clk) disable iff (i_reset)
    state == st_wait && !i_clear_ok |=> o_shutdown)
    else $error("restart while temperature still over limit");
  c_latched: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_latched));
  c_retry: cover property (@(posedge i_clk) disable iff (i_reset) state == st_wait ##1 state == st_run);
endmodule

// ==== core/fault_track_pkg.sv ====
package fault_track_pkg;
  // register byte offsets (one aligned word each)
  localparam logic [5:0] OFS_CTRL      = 6'h00;
  localparam logic [5:0] OFS_TRACK_CFG = 6'h04;
  localparam logic [5:0] OFS_OC_RESP   = 6'h08;
  localparam logic [5:0] OFS_OT_RESP   = 6'h0c;
  localparam logic [5:0] OFS_OT_LIMIT  = 6'h10;
  localparam logic [5:0] OFS_TIMING    = 6'h14;
  localparam logic [5:0] OFS_TARGET    = 6'h18;
  localparam logic [5:0] OFS_STATUS    = 6'h1c;
  localparam logic [5:0] OFS_GAIN      = 6'h20;

  // fault response codes
  localparam logic [2:0] FR_IMMEDIATE = 3'h0;
  localparam logic [2:0] FR_RETRY_INF = 3'h1;
  localparam logic [2:0] FR_RETRY_CNT = 3'h2;
  localparam logic [2:0] FR_DELAYED   = 3'h3;
  localparam logic [2:0] FR_CONTINUE  = 3'h4;

  typedef struct packed {
    logic [7:0] delay_ms;
    logic       rsvd;
    logic [2:0] retries;
    logic       rsvd2;
    logic [2:0] mode;
  } fault_cfg_t;

  typedef struct packed {
    logic ratio_half;
    logic ref_limited;
    logic follow_always;
  } track_sel_t;

  typedef struct packed {
    logic       restart;
    logic       auto_comp;
    logic       track_from_reg;
    logic       sw_on;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] off_fall;
    logic [7:0] off_dly;
    logic [7:0] on_rise;
    logic [7:0] on_dly;
  } timing_t;

  typedef struct packed {
    logic       ss_valid;
    logic [2:0] ss_sel;
    logic [7:0] temp;
    logic       track_active;
    logic       ot_latched;
    logic       ot_shutdown;
    logic       oc_latched;
    logic       oc_shutdown;
    logic       drive_on;
    logic       power_good;
  } status_t;

  localparam logic [15:0] FAULT_CFG_RST = 16'h0000;
  localparam logic [7:0]  OT_LIMIT_RST  = 8'h7d;
  localparam logic [7:0]  OT_HYST_C     = 8'h0f;
  localparam logic [31:0] TIMING_RST    = 32'h05050505;
  localparam logic [15:0] TARGET_RST    = 16'h03e8;
  localparam logic [7:0]  GAIN_RST      = 8'h10;

  // tracking set by resistor: times in ms
  localparam logic [7:0] TRK_ON_DLY_MS  = 8'h05;
  localparam logic [7:0] TRK_OFF_DLY_MS = 8'h23;
  localparam logic [7:0] TRK_RAMP_MS    = 8'h02;

  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

  // soft-start resistor in 0.1 kohm steps, window bounds and bin edges
  localparam logic [11:0] RSS_MIN = 12'h35c;
  localparam logic [11:0] RSS_MAX = 12'h74e;
  localparam logic [11:0] RSS_E1  = 12'h3bb;
  localparam logic [11:0] RSS_E2  = 12'h41a;
  localparam logic [11:0] RSS_E3  = 12'h487;
  localparam logic [11:0] RSS_E4  = 12'h4fb;
  localparam logic [11:0] RSS_E5  = 12'h57c;
  localparam logic [11:0] RSS_E6  = 12'h60b;
  localparam logic [11:0] RSS_E7  = 12'h6a4;
endpackage

// ==== core/fault_track_seq.sv ====
`timescale 1ns/1ps
// Behaviour
// - overcurrent: five selectable fault responses
// - overcurrent default: shut down immediately
// - default shutdown re-enables once fault clears
// - over-temperature shuts down; limit resets 125
// - temperature fault: same five responses
// - thermal restart after delay, 15 degrees hysteresis
// - still hot: wait another delay, retry
// - thermal default immediate, auto re-enable
// - tracking uses reference input as set point
// - resistor decodes into eight tracking settings
// - resistor tracking: 5ms on, 35ms off, 2ms
// - coincident target-limited: follow, stop at target
// - coincident reference-limited: follow without clamp
// - ratiometric target-limited: half ratio, half target
// - ratiometric reference-limited: half rail or target
// - tracking ignores own soft-start delay
// - tracking selectable by register instead of resistor
// - auto compensation: ramp gain from rise/fall times
module fault_track_seq import fault_track_pkg::*; #(
  parameter int MS_CYCLES = CYCLES_PER_MS
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_enable_pin,
  input  wire logic        i_oc_fault,
  input  wire logic [7:0]  i_temp,
  input  wire logic [15:0] i_tracking_reference_input,
  input  wire logic [11:0] i_ss_res,
  output logic             o_drive_on,
  output logic             o_power_good,
  output logic [15:0]      o_ref_mv,
  output logic [15:0]      o_ramp_gain
);
  initial begin
    if (MS_CYCLES < 1) $error("fault_track_seq: MS_CYCLES must be at least 1");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // nearest standard value; outside the window tracking is not selected
  function automatic logic [3:0] ss_decode(input logic [11:0] r);
    logic [3:0] d;
    d = 4'h0;
    if (r >= RSS_MIN && r <= RSS_MAX) begin
      if (r < RSS_E1)      d = 4'h8;
      else if (r < RSS_E2) d = 4'h9;
      else if (r < RSS_E3) d = 4'ha;
      else if (r < RSS_E4) d = 4'hb;
      else if (r < RSS_E5) d = 4'hc;
      else if (r < RSS_E6) d = 4'hd;
      else if (r < RSS_E7) d = 4'he;
      else                 d = 4'hf;
    end
    return d;
  endfunction

  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  // linear ramp point; a zero duration jumps straight to the end value
  function automatic logic [15:0] ramp_mv(input logic [15:0] tgt, input logic [7:0] t, input logic [7:0] dur);
    logic [23:0] p;
    p = 24'(tgt) * 24'(t);
    if (dur == 8'h0 || t >= dur) return tgt;
    p = p / 24'(dur);
    return p[15:0];
  endfunction

  // ------------------------------------------------------------------ registers
  ctrl_t       ctrl;
  logic [3:0]  trk_reg;
  fault_cfg_t  oc_cfg;
  fault_cfg_t  ot_cfg;
  logic [7:0]  ot_limit;
  timing_t     timing;
  logic [15:0] target;
  logic [7:0]  man_gain;
  status_t     status;
  logic        done;
  logic        wr_hit;
  logic        req;

  assign req               = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && !done;
  assign wr_hit            = i_avs_write && done; // lands only at the edge where waitrequest is low

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) done <= 1'b0;
    else         done <= req && !done;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl     <= '0;
      trk_reg  <= 4'h0;
      oc_cfg   <= FAULT_CFG_RST;
      ot_cfg   <= FAULT_CFG_RST;
      ot_limit <= OT_LIMIT_RST;
      timing   <= TIMING_RST;
      target   <= TARGET_RST;
      man_gain <= GAIN_RST;
    end else begin
      ctrl.restart <= 1'b0;
      if (wr_hit) begin
        unique case ({i_avs_address[5:2], 2'b00})
          OFS_CTRL:      ctrl     <= ctrl_t'(merge(32'(ctrl), i_avs_writedata, i_avs_byteenable));
          OFS_TRACK_CFG: trk_reg  <= 4'(merge(32'(trk_reg), i_avs_writedata, i_avs_byteenable));
          OFS_OC_RESP:   oc_cfg   <= fault_cfg_t'(16'(merge(32'(oc_cfg), i_avs_writedata, i_avs_byteenable)));
          OFS_OT_RESP:   ot_cfg   <= fault_cfg_t'(16'(merge(32'(ot_cfg), i_avs_writedata, i_avs_byteenable)));
          OFS_OT_LIMIT:  ot_limit <= 8'(merge(32'(ot_limit), i_avs_writedata, i_avs_byteenable));
          OFS_TIMING:    timing   <= timing_t'(merge(32'(timing), i_avs_writedata, i_avs_byteenable));
          OFS_TARGET:    target   <= 16'(merge(32'(target), i_avs_writedata, i_avs_byteenable));
          OFS_GAIN:      man_gain <= 8'(merge(32'(man_gain), i_avs_writedata, i_avs_byteenable));
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && !done) begin
      unique case ({i_avs_address[5:2], 2'b00})
        OFS_CTRL:      o_avs_readdata <= 32'({ctrl[2:0]});
        OFS_TRACK_CFG: o_avs_readdata <= 32'(trk_reg);
        OFS_OC_RESP:   o_avs_readdata <= 32'(oc_cfg);
        OFS_OT_RESP:   o_avs_readdata <= 32'(ot_cfg);
        OFS_OT_LIMIT:  o_avs_readdata <= 32'(ot_limit);
        OFS_TIMING:    o_avs_readdata <= 32'(timing);
        OFS_TARGET:    o_avs_readdata <= 32'(target);
        OFS_STATUS:    o_avs_readdata <= 32'(status);
        OFS_GAIN:      o_avs_readdata <= 32'(man_gain);
        default:       o_avs_readdata <= 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------------ pin inputs
  logic en_meta, en_sync, oc_meta, oc_sync, en_prev;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      oc_meta <= 1'b0;
      oc_sync <= 1'b0;
    end else begin
      en_meta <= i_enable_pin;
      en_sync <= en_meta;
      oc_meta <= i_oc_fault;
      oc_sync <= oc_meta;
    end
  end

  logic enable;
  logic restart;
  assign enable = en_sync || ctrl.sw_on;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) en_prev <= 1'b0;
    else         en_prev <= enable;
  end

  // a fresh enable edge or a software restart rearms latched responders
  assign restart = (enable && !en_prev) || ctrl.restart;

  // ------------------------------------------------------------------ faults
  logic tick;
  logic oc_sd, oc_lat, ot_sd, ot_lat;
  logic ot_fault, ot_cool;

  ms_tick #(.DIV(MS_CYCLES)) u_tick (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .o_tick  (tick)
  );

  assign ot_fault = $signed(i_temp) > $signed(ot_limit);
  // hysteresis below the limit keeps a hot module from chattering on and off
  assign ot_cool  = $signed(i_temp) < $signed(ot_limit - OT_HYST_C);

  fault_resp u_oc (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_tick     (tick),
    .i_fault    (oc_sync),
    .i_clear_ok (!oc_sync),
    .i_restart  (restart),
    .i_cfg      (oc_cfg),
    .o_shutdown (oc_sd),
    .o_latched  (oc_lat)
  );

  fault_resp u_ot (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_tick     (tick),
    .i_fault    (ot_fault),
    .i_clear_ok (ot_cool),
    .i_restart  (restart),
    .i_cfg      (ot_cfg),
    .o_shutdown (ot_sd),
    .o_latched  (ot_lat)
  );

  // ------------------------------------------------------------------ tracking selection
  logic [3:0] ss_dec;
  logic       trk_on;
  track_sel_t trk;

  assign ss_dec = ss_decode(i_ss_res);
  assign trk_on = ctrl.track_from_reg ? trk_reg[3] : ss_dec[3];
  assign trk    = ctrl.track_from_reg ? track_sel_t'(trk_reg[2:0]) : track_sel_t'(ss_dec[2:0]);

  logic [15:0] scaled, trk_mv;

  always_comb begin
    scaled = trk.ratio_half ? {1'b0, i_tracking_reference_input[15:1]} : i_tracking_reference_input;
    if (trk.ref_limited) begin
      trk_mv = trk.ratio_half ? min16(scaled, target) : scaled;
    end else begin
      trk_mv = min16(scaled, trk.ratio_half ? {1'b0, target[15:1]} : target);
    end
  end

  // ------------------------------------------------------------------ sequencer
  typedef enum logic [2:0] {s_off, s_on_dly, s_rise, s_on, s_off_dly, s_fall} seq_t;
  seq_t       seq;
  logic [7:0] t_ms;
  logic [7:0] on_dly, rise, off_dly, fall;

  // tracking replaces the programmed soft-start figures
  assign on_dly  = trk_on ? TRK_ON_DLY_MS  : timing.on_dly;
  assign rise    = trk_on ? TRK_RAMP_MS    : timing.on_rise;
  assign off_dly = trk_on ? TRK_OFF_DLY_MS : timing.off_dly;
  assign fall    = trk_on ? TRK_RAMP_MS    : timing.off_fall;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      seq  <= s_off;
      t_ms <= 8'h0;
    end else begin
      if (tick && t_ms != 8'hff) t_ms <= t_ms + 8'h1;
      unique case (seq)
        s_off: if (enable) begin
          seq  <= s_on_dly;
          t_ms <= 8'h0;
        end
        s_on_dly: if (!enable) begin
          seq <= s_off;
        end else if (t_ms >= on_dly) begin
          seq  <= s_rise;
          t_ms <= 8'h0;
        end
        s_rise, s_on: if (!enable) begin
          seq  <= s_off_dly;
          t_ms <= 8'h0;
        end else if (seq == s_rise && t_ms >= rise) begin
          seq <= s_on;
        end
        s_off_dly, s_fall: if (enable) begin
          seq  <= s_on_dly;
          t_ms <= 8'h0;
        end else if (seq == s_off_dly && t_ms >= off_dly) begin
          seq  <= s_fall;
          t_ms <= 8'h0;
        end else if (seq == s_fall && t_ms >= fall) begin
          seq <= s_off;
        end
      endcase
    end
  end

  logic [15:0] next_ref;

  always_comb begin
    next_ref = 16'h0;
    if (trk_on) begin
      unique case (seq)
        s_rise, s_on, s_off_dly: begin
          next_ref = trk_mv;
          // held-up ramp: the output may not dip until power good
          if (!trk.follow_always && seq == s_rise && trk_mv < o_ref_mv) next_ref = o_ref_mv;
        end
        default: next_ref = 16'h0;
      endcase
    end else begin
      unique case (seq)
        s_rise:    next_ref = ramp_mv(target, t_ms, rise);
        s_on:      next_ref = target;
        s_off_dly: next_ref = target;
        s_fall:    next_ref = target - ramp_mv(target, t_ms, fall);
        default:   next_ref = 16'h0;
      endcase
    end
  end

  logic running;
  assign running = (seq != s_off) && (seq != s_on_dly) && !oc_sd && !ot_sd;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ref_mv     <= 16'h0;
      o_drive_on   <= 1'b0;
      o_power_good <= 1'b0;
    end else begin
      o_ref_mv     <= running ? next_ref : 16'h0;
      o_drive_on   <= running;
      o_power_good <= running && seq == s_on;
    end
  end

  // slope of the active ramp sets the loop gain under auto compensation
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ramp_gain <= 16'h0;
    end else if (ctrl.auto_comp && seq == s_rise) begin
      o_ramp_gain <= ramp_mv(target, 8'h1, rise);
    end else if (ctrl.auto_comp && seq == s_fall) begin
      o_ramp_gain <= ramp_mv(target, 8'h1, fall);
    end else begin
      o_ramp_gain <= 16'(man_gain);
    end
  end

  always_comb begin
    status              = '0;
    status.power_good   = o_power_good;
    status.drive_on     = o_drive_on;
    status.oc_shutdown  = oc_sd;
    status.oc_latched   = oc_lat;
    status.ot_shutdown  = ot_sd;
    status.ot_latched   = ot_lat;
    status.track_active = trk_on;
    status.temp         = i_temp;
    status.ss_sel       = ss_dec[2:0];
    status.ss_valid     = ss_dec[3];
  end

  a_fault_drive_off: assert property (@(posedge i_clk) disable iff (i_reset)
    oc_sd || ot_sd |=> !o_drive_on)
    else $error("drive on while a fault shutdown is active");
  a_trk_target_clamp: assert property (@(posedge i_clk) disable iff (i_reset)
    trk_on && !trk.ref_limited && !trk.ratio_half && seq == s_on && running |=> o_ref_mv <= target)
    else $error("coincident target-limited reference above target");
  a_trk_half_clamp: assert property (@(posedge i_clk) disable iff (i_reset)
    trk_on && !trk.ref_limited && trk.ratio_half && seq == s_on && running |=> o_ref_mv <= {1'b0, target[15:1]})
    else $error("ratiometric target-limited reference above half target");
  a_trk_on_delay: assert property (@(posedge i_clk) disable iff (i_reset)
    trk_on && seq == s_on_dly && t_ms < TRK_ON_DLY_MS && enable |=> seq != s_rise)
    else $error("tracking turn-on delay cut short");
  a_bus_one_wait: assert property (@(posedge i_clk) disable iff (i_reset)
    req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer took more than one wait cycle");
  c_pg: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_power_good));
  c_trk_ramp: cover property (@(posedge i_clk) disable iff (i_reset) trk_on && seq == s_rise && running);
  c_oc_off: cover property (@(posedge i_clk) disable iff (i_reset) $rose(oc_sd));
endmodule

// ==== core/ms_tick.sv ====
`timescale 1ns/1ps
module ms_tick #(
  parameter int DIV = 50000
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  output logic      o_tick
);
  initial begin
    if (DIV < 1) $error("ms_tick: DIV must be at least 1");
  end

  logic [31:0] cnt;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt    <= 32'h0;
      o_tick <= 1'b0;
    end else if (cnt == 32'(DIV - 1)) begin
      cnt    <= 32'h0;
      o_tick <= 1'b1;
    end else begin
      cnt    <= cnt + 32'h1;
      o_tick <= 1'b0;
    end
  end
endmodule

// ==== verification/fault_response_tracking_seq_tb.sv ====
`timescale 1ns/1ps
module fault_response_tracking_seq_tb;
  import fault_track_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd  = 1'b0;
  logic        wr  = 1'b0;
  logic        en  = 1'b0;
  logic        oc  = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wd  = 32'h0;
  logic [7:0]  tmp = 8'h19;
  logic [11:0] rss = 12'h000;
  logic [15:0] lvl = 16'h04b0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        wq;
  logic        drv;
  logic        pg;
  logic [15:0] trk;
  logic [15:0] refmv;
  logic [15:0] gain;
  int          n_errors = 0;
  int          compares = 0;
  always #10 clk = ~clk;
  fault_track_seq #(.MS_CYCLES(20)) DUT (
    .i_clk(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_enable_pin(en),
    .i_oc_fault(oc), .i_temp(tmp), .i_tracking_reference_input(trk),
    .i_ss_res(rss), .o_drive_on(drv), .o_power_good(pg), .o_ref_mv(refmv),
    .o_ramp_gain(gain));
  // one enable source feeds both rails; 130 cycles is 6.5 ms at the bench tick
  ref_rail #(.DLY(130)) RAIL (.i_clk(clk), .i_en(en), .i_level(lvl), .o_trk(trk));
  task conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // only the watchdog ends a wait that never gets an answer
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // sel picks power good or drive; bounded so a stuck output is reported
  task wt(input logic sel, input logic v);
    int k;
    k = 0;
    while ((sel ? pg : drv) !== v && k < 4000) begin
      @(posedge clk);
      k++;
    end
    chk(sel ? "pg" : "drive", {31'h0, v}, {31'h0, sel ? pg : drv});
  endtask
  task trk_case(input logic [31:0] cfg, input logic [15:0] e);
    bus(1'b1, OFS_TRACK_CFG, cfg);
    en <= 1'b1;
    wt(1'b1, 1'b1);
    repeat (200) @(posedge clk);
    chk("ref_mv", {16'h0, e}, {16'h0, refmv});
    en <= 1'b0;
    wt(1'b0, 1'b0);
    repeat (20) @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFS_OT_LIMIT, 32'h0);
    chk("ot_limit", 32'h7d, q);
    bus(1'b0, OFS_OC_RESP, 32'h0);
    chk("oc_resp", 32'h0, q);
    bus(1'b0, 6'h3c, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, OFS_TIMING, 32'h05050505);
    bus(1'b1, OFS_CTRL, 32'h4);
    en <= 1'b1;
    wt(1'b0, 1'b1);
    chk("ramp_gain", 32'hc8, {16'h0, gain});
    wt(1'b1, 1'b1);
    chk("man_gain", 32'h10, {16'h0, gain});
    oc <= 1'b1;
    repeat (6) @(posedge clk);
    chk("oc_off", 32'h0, {31'h0, drv});
    oc <= 1'b0;
    wt(1'b0, 1'b1);
    bus(1'b1, OFS_OT_LIMIT, 32'h50);
    tmp <= 8'h51;
    repeat (6) @(posedge clk);
    chk("ot_off", 32'h0, {31'h0, drv});
    // 70 is below the limit but inside the hysteresis band
    tmp <= 8'h46;
    repeat (300) @(posedge clk);
    chk("ot_hyst", 32'h0, {31'h0, drv});
    tmp <= 8'h40;
    wt(1'b0, 1'b1);
    bus(1'b1, OFS_OC_RESP, 32'h0112);
    oc <= 1'b1;
    repeat (100) @(posedge clk);
    oc <= 1'b0;
    wt(1'b0, 1'b1);
    oc <= 1'b1;
    repeat (100) @(posedge clk);
    oc <= 1'b0;
    repeat (200) @(posedge clk);
    chk("cnt_latch", 32'h0, {31'h0, drv});
    bus(1'b1, OFS_CTRL, 32'h8);
    wt(1'b0, 1'b1);
    bus(1'b1, OFS_OT_RESP, 32'h4);
    tmp <= 8'h60;
    repeat (6) @(posedge clk);
    chk("ot_continue", 32'h1, {31'h0, drv});
    tmp <= 8'h40;
    en <= 1'b0;
    wt(1'b0, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h2);
    trk_case(32'ha, 16'h04b0);
    trk_case(32'h8, 16'h03e8);
    trk_case(32'hc, 16'h01f4);
    trk_case(32'he, 16'h0258);
    bus(1'b1, OFS_CTRL, 32'h0);
    rss <= 12'h3e8;
    repeat (4) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("ss_valid", 32'h1, {31'h0, q[18]});
    chk("ss_sel", 32'h1, {29'h0, q[17:15]});
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule

// ==== verification/ref_rail.sv ====
`timescale 1ns/1ps
module ref_rail #(
  parameter int DLY = 130
) (
  input  wire logic        i_clk,
  input  wire logic        i_en,
  input  wire logic [15:0] i_level,
  output logic [15:0]      o_trk = 16'h0000
);
  int held = 0;

  // untracked upstream rail: waits out its own turn-on delay, then ramps slowly
  always_ff @(posedge i_clk) begin
    if (!i_en) held <= 0;
    else if (held < DLY) held <= held + 1;
  end

  always_ff @(posedge i_clk) begin
    if (i_en && held >= DLY && o_trk < i_level) o_trk <= o_trk + 16'h0008;
    else if (!i_en && o_trk > 16'h0007) o_trk <= o_trk - 16'h0008;
    else if (!i_en) o_trk <= 16'h0000;
  end
endmodule
